// ==== rtct_core.v ====
// Purpose: RTC calendar with init handshake, alarms, tamper timestamp and key lock
// Assumes: One 20 MHz clock; tamper, oscillator-stop and halt inputs are asynchronous
// Notes:   Kernel clock is a divided one-cycle enable
// Operation
// - Init-ready rises one to two kernel ticks after init request, never at once.
// - Time and date writes are ignored while init-ready is low.
// - With stop-in-debug set, a halted core also stops the subsecond downcounter.
// - Nonzero subsecond mask brings subsecond bits into the alarm match.
// - Tamper with timestamp enabled and flag clear sets flag and captures calendar.
// - Tamper while timestamp flag is set raises the overflow flag instead.
// - Tamper is ignored four bus cycles after clear, two prescaler ticks after clearing.
// - Reference-clock detect unlock needs the key under calibration rights.
// - Oscillator stop sets internal tamper 3 flags and erases or blocks backups.
// - While the oscillator is stopped the timestamp flag and its masked flag stay low.
// - RTC and tamper units each have a read-only version register.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rtct_regs.vh"
module rtct_core #(
  parameter KCLK_DIV     = `RTCT_KCLK_DIV,
  parameter RTC_VERSION  = 32'h0000_0011,  // Arbitrary value
  parameter TAMP_VERSION = 32'h0000_0022   // Arbitrary value
) (
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        reset_i,
  // Register port
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  input  wire        bus_priv_i,
  input  wire        bus_sec_i,
  output reg  [31:0] rdata_o,
  // Asynchronous pins
  input  wire        tamper_i,
  input  wire        osc_stopped_i,
  input  wire        dbg_halt_i,
  // Status out
  output reg         secrets_erase_o
);
  // Registers
  reg  [7:0]  ctrl_reg;
  reg  [3:0]  rights_reg;
  reg  [1:0]  tcfg_reg;
  reg  [31:0] alr_reg [0:3];
  reg  [31:0] bkp_reg [0:3];
  reg  [31:0] ts_time_reg, ts_date_reg, ts_ss_reg;
  reg         init_ready_flag, registers_synced_flag;
  reg         alarm_a_flag, alarm_b_flag;
  reg         timestamp_flag, timestamp_overflow_flag;
  reg         internal_tamper3_flag;
  reg         init_unl_reg, cal_unl_reg, key1_init_reg, key1_cal_reg;
  reg  [1:0]  init_cnt_reg, rsf_cnt_reg;
  reg  [2:0]  tsclr_cnt_reg;
  reg  [1:0]  apwin_cnt_reg;
  reg  [9:0]  kdiv_reg;
  reg         kclk_en;
  reg  [1:0]  tamp_sync, osc_sync, halt_sync;
  reg         tamp_d, osc_d;
  integer     i, j;
  wire [14:0] subsec;
  wire [16:0] secs;
  wire [15:0] days;
  wire        apre_tick;
  // Access rights check for a given privilege and security requirement
  function rights_ok;
    input need_priv, need_sec, priv, sec;
    begin
      rights_ok = (~need_priv | priv) & (~need_sec | sec);
    end
  endfunction
  // Alarm subsecond compare on the low mask-count bits
  function ss_match;
    input [14:0] ss, alss;
    input [3:0]  mask;
    reg   [14:0] m;
    begin
      m        = (mask >= 4'hF) ? 15'h7FFF : ((15'h0001 << mask) - 15'h0001);
      ss_match = ((ss & m) == (alss & m));
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detect after the second stage
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      tamp_sync <= 2'h0;
      osc_sync  <= 2'h0;
      halt_sync <= 2'h0;
      tamp_d    <= 1'b0;
      osc_d     <= 1'b0;
    end else begin
      tamp_sync <= {tamp_sync[0], tamper_i};
      osc_sync  <= {osc_sync[0], osc_stopped_i};
      halt_sync <= {halt_sync[0], dbg_halt_i};
      tamp_d    <= tamp_sync[1];
      osc_d     <= osc_sync[1];
    end
  end
  wire tamper_evt = tamp_sync[1] & ~tamp_d;
  wire osc_stop   = osc_sync[1];
  wire osc_evt    = osc_sync[1] & ~osc_d;
  ////////////////////////////////////////////////////////////////////////
  // Kernel clock tick; no tick while the oscillator is stopped
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      kdiv_reg <= 10'h000;
      kclk_en  <= 1'b0;
    end else begin
      kclk_en  <= (kdiv_reg == 10'h000) & ~osc_stop;
      kdiv_reg <= (kdiv_reg == 10'h000) ? KCLK_DIV[9:0] - 10'h001 : kdiv_reg - 10'h001;
    end
  end
  // Bus decode
  wire wr_ctrl = wr_i && (addr_i == `RTCT_CTRL);
  wire wr_clr  = wr_i && (addr_i == `RTCT_CLEAR);
  wire wr_key  = wr_i && (addr_i == `RTCT_KEY);
  wire ld_time = wr_i && (addr_i == `RTCT_TIME) && init_ready_flag;
  wire ld_date = wr_i && (addr_i == `RTCT_DATE) && init_ready_flag;
  wire run     = ~init_ready_flag & ~(ctrl_reg[`RTCT_C_DBGSTOP] & halt_sync[1]);
  rtct_calendar u_cal (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .kclk_en_i   (kclk_en),
    .run_i       (run),
    .load_time_i (ld_time),
    .load_date_i (ld_date),
    .wdata_i     (wdata_i),
    .subsec_o    (subsec),
    .secs_o      (secs),
    .days_o      (days),
    .apre_tick_o (apre_tick)
  );
  ////////////////////////////////////////////////////////////////////////
  // Key sequence; each key is judged under its own rights setting
  wire init_rt = rights_ok(rights_reg[`RTCT_R_INITIALIZATION_PRIVILEGE], rights_reg[`RTCT_R_INITIALIZATION_SECURITY],
                           bus_priv_i, bus_sec_i);
  wire cal_rt  = rights_ok(rights_reg[`RTCT_R_CALIBRATION_PRIVILEGE], rights_reg[`RTCT_R_CALIBRATION_SECURITY],
                           bus_priv_i, bus_sec_i);
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      key1_init_reg <= 1'b0;
      key1_cal_reg  <= 1'b0;
      init_unl_reg  <= 1'b0;
      cal_unl_reg   <= 1'b0;
    end else if (wr_key) begin
      key1_init_reg <= (wdata_i[7:0] == `RTCT_KEY1) & init_rt;
      init_unl_reg  <= (wdata_i[7:0] == `RTCT_KEY2) & init_rt & key1_init_reg;
      key1_cal_reg  <= (wdata_i[7:0] == `RTCT_KEY1) & cal_rt;
      cal_unl_reg   <= (wdata_i[7:0] == `RTCT_KEY2) & cal_rt & key1_cal_reg;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Control, rights, tamper config and alarm registers
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      ctrl_reg   <= 8'h00;
      rights_reg <= 4'h0;
      tcfg_reg   <= 2'h0;
      for (i = 0; i < 4; i = i + 1)
        alr_reg[i] <= 32'h0000_0000;
    end else if (wr_i) begin
      if (wr_ctrl && init_unl_reg) begin
        ctrl_reg[4:0] <= wdata_i[4:0];
        ctrl_reg[7:6] <= wdata_i[7:6];
      end
      if (wr_ctrl && cal_unl_reg)
        ctrl_reg[`RTCT_C_REFCK] <= wdata_i[`RTCT_C_REFCK];
      if (addr_i == `RTCT_RIGHTS)
        rights_reg <= wdata_i[3:0];
      if (addr_i == `RTCT_TAMP_CFG)
        tcfg_reg <= wdata_i[1:0];
      if (addr_i >= `RTCT_ALRA && addr_i <= `RTCT_ALRB_SS && init_unl_reg)
        alr_reg[addr_i[3:2] - 2'h2] <= wdata_i;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // init handshake and synced flag
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      init_ready_flag       <= 1'b0;
      registers_synced_flag <= 1'b0;
      init_cnt_reg          <= 2'h0;
      rsf_cnt_reg           <= 2'h0;
    end else if (!ctrl_reg[`RTCT_C_INIT]) begin
      init_ready_flag <= 1'b0;
      init_cnt_reg    <= 2'h0;
      if (init_ready_flag || ld_time || ld_date) begin
        registers_synced_flag <= 1'b0;
        rsf_cnt_reg           <= 2'h0;
      end else if (kclk_en && !registers_synced_flag && !ctrl_reg[`RTCT_C_BYPSH]) begin
        rsf_cnt_reg <= rsf_cnt_reg + 2'h1;
        if (rsf_cnt_reg + 2'h1 == `RTCT_INIT_TICKS) begin
          registers_synced_flag <= 1'b1;
        end
      end
    end else if (!init_ready_flag && kclk_en) begin
      init_cnt_reg <= init_cnt_reg + 2'h1;
      if (init_cnt_reg + 2'h1 == `RTCT_INIT_TICKS) begin
        init_ready_flag <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm flags: evaluated per subsecond tick, so a halted counter stops them
  wire alra_hit = apre_tick & ctrl_reg[`RTCT_C_ALRAEN] & (secs == alr_reg[0][16:0])
                & ss_match(subsec, alr_reg[2][14:0], alr_reg[2][27:24]);
  wire alrb_hit = apre_tick & ctrl_reg[`RTCT_C_ALRBEN] & (secs == alr_reg[1][16:0])
                & ss_match(subsec, alr_reg[3][14:0], alr_reg[3][27:24]);
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      alarm_a_flag <= 1'b0;
      alarm_b_flag <= 1'b0;
    end else begin
      alarm_a_flag <= alra_hit | (alarm_a_flag & ~(wr_clr & wdata_i[`RTCT_S_ALRA]));
      alarm_b_flag <= alrb_hit | (alarm_b_flag & ~(wr_clr & wdata_i[`RTCT_S_ALRB]));
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Timestamp on tamper with clear windows
  // blind windows after clear
  wire ts_blind = (tsclr_cnt_reg != 3'h0) | (apwin_cnt_reg != 2'h0);
  wire ts_evt   = tamper_evt & ctrl_reg[`RTCT_C_TSEN] & ~osc_stop & ~ts_blind;
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      timestamp_flag          <= 1'b0;
      timestamp_overflow_flag <= 1'b0;
      tsclr_cnt_reg           <= 3'h0;
      apwin_cnt_reg           <= 2'h0;
      ts_time_reg             <= 32'h0000_0000;
      ts_date_reg             <= 32'h0000_0000;
      ts_ss_reg               <= 32'h0000_0000;
    end else begin
      if (wr_clr && wdata_i[`RTCT_S_TS] && timestamp_flag && tsclr_cnt_reg == 3'h0) begin
        tsclr_cnt_reg <= `RTCT_TSCLR_APB;
      end else if (tsclr_cnt_reg != 3'h0) begin
        tsclr_cnt_reg <= tsclr_cnt_reg - 3'h1;
      end
      if (tsclr_cnt_reg == 3'h1) begin
        apwin_cnt_reg <= `RTCT_TSCLR_APRE;
      end else if (apre_tick && apwin_cnt_reg != 2'h0) begin
        apwin_cnt_reg <= apwin_cnt_reg - 2'h1;
      end
      if (osc_stop) begin
        timestamp_flag <= 1'b0;
      end else if (ts_evt && !timestamp_flag) begin
        timestamp_flag <= 1'b1;
        ts_time_reg    <= {15'h0000, secs};
        ts_date_reg    <= {16'h0000, days};
        ts_ss_reg      <= {17'h00000, subsec};
      end else if (tsclr_cnt_reg == 3'h1) begin
        timestamp_flag <= 1'b0;
      end
      timestamp_overflow_flag <= (ts_evt & timestamp_flag)
                               | (timestamp_overflow_flag & ~(wr_clr & wdata_i[`RTCT_S_TSOV]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // internal tamper 3 and backup registers
  wire bkp_sel = addr_i >= `RTCT_BKP_BASE && addr_i < `RTCT_VER_RTC;
  wire erase   = osc_evt & ~tcfg_reg[`RTCT_T_IT3BLOCK];
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      internal_tamper3_flag <= 1'b0;
      secrets_erase_o       <= 1'b0;
      for (j = 0; j < 4; j = j + 1)
        bkp_reg[j] <= 32'h0000_0000;
    end else begin
      internal_tamper3_flag <= osc_evt
                             | (internal_tamper3_flag & ~(wr_clr & wdata_i[`RTCT_S_IT3]));
      secrets_erase_o       <= erase;
      if (erase) begin
        for (j = 0; j < 4; j = j + 1)
          bkp_reg[j] <= 32'h0000_0000;
      end else if (wr_i && bkp_sel && !internal_tamper3_flag) begin
        bkp_reg[addr_i[3:2]] <= wdata_i;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Read data, valid in the cycle after the read strobe
  wire it3m = internal_tamper3_flag & tcfg_reg[`RTCT_T_IT3IE];
  wire tsm  = timestamp_flag & ctrl_reg[`RTCT_C_TSIE];
  wire [31:0] status = {20'h00000, cal_unl_reg, init_unl_reg, osc_stop, it3m,
                        internal_tamper3_flag, tsm, timestamp_overflow_flag,
                        timestamp_flag, alarm_b_flag, alarm_a_flag,
                        registers_synced_flag, init_ready_flag};
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      case (addr_i)
        `RTCT_CTRL:      rdata_o <= {24'h000000, ctrl_reg};
        `RTCT_STATUS:    rdata_o <= status;
        `RTCT_TIME:      rdata_o <= {15'h0000, secs};
        `RTCT_DATE:      rdata_o <= {16'h0000, days};
        `RTCT_SUBSEC:    rdata_o <= {17'h00000, subsec};
        `RTCT_ALRA:      rdata_o <= alr_reg[0];
        `RTCT_ALRB:      rdata_o <= alr_reg[1];
        `RTCT_ALRA_SS:   rdata_o <= alr_reg[2];
        `RTCT_ALRB_SS:   rdata_o <= alr_reg[3];
        `RTCT_TS_TIME:   rdata_o <= ts_time_reg;
        `RTCT_TS_DATE:   rdata_o <= ts_date_reg;
        `RTCT_TS_SS:     rdata_o <= ts_ss_reg;
        `RTCT_RIGHTS:    rdata_o <= {28'h0000000, rights_reg};
        `RTCT_TAMP_CFG:  rdata_o <= {30'h00000000, tcfg_reg};
        `RTCT_VER_RTC:   rdata_o <= RTC_VERSION;
        `RTCT_VER_TAMP:  rdata_o <= TAMP_VERSION;
        default: begin
          // Backups read zero while blocked by tamper 3
          rdata_o <= (bkp_sel && !internal_tamper3_flag) ? bkp_reg[addr_i[3:2]] : 32'h0000_0000;
        end
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// ==== rtct_regs.vh ====
// Purpose: Register map, field positions and counts of the RTC calendar block
// Assumes: Included by bare name from the design files
// Notes:   Definitions only
`ifndef RTCT_REGS_VH
`define RTCT_REGS_VH
// Register offsets (byte addresses, one word each)
`define RTCT_CTRL        8'h00
`define RTCT_STATUS      8'h04
`define RTCT_CLEAR       8'h08
`define RTCT_TIME        8'h0C
`define RTCT_DATE        8'h10
`define RTCT_SUBSEC      8'h14
`define RTCT_ALRA        8'h18
`define RTCT_ALRB        8'h1C
`define RTCT_ALRA_SS     8'h20
`define RTCT_ALRB_SS     8'h24
`define RTCT_TS_TIME     8'h28
`define RTCT_TS_DATE     8'h2C
`define RTCT_TS_SS       8'h30
`define RTCT_KEY         8'h34
`define RTCT_RIGHTS      8'h38
`define RTCT_TAMP_CFG    8'h3C
`define RTCT_BKP_BASE    8'h40
`define RTCT_VER_RTC     8'h50
`define RTCT_VER_TAMP    8'h54
// Control fields
`define RTCT_C_INIT      0
`define RTCT_C_BYPSH     1
`define RTCT_C_DBGSTOP   2
`define RTCT_C_TSEN      3
`define RTCT_C_TSIE      4
`define RTCT_C_REFCK     5
`define RTCT_C_ALRAEN    6
`define RTCT_C_ALRBEN    7
// Status and clear fields
`define RTCT_S_INIT_READY_FLAG     0
`define RTCT_S_RSF       1
`define RTCT_S_ALRA      2
`define RTCT_S_ALRB      3
`define RTCT_S_TS        4
`define RTCT_S_TSOV      5
`define RTCT_S_TSM       6
`define RTCT_S_IT3       7
`define RTCT_S_IT3M      8
`define RTCT_S_OSCSTOP   9
`define RTCT_S_INITUNL   10
`define RTCT_S_CALUNL    11
// Write-protection keys and rights fields
`define RTCT_KEY1        8'hCA
`define RTCT_KEY2        8'h53
`define RTCT_R_INITIALIZATION_PRIVILEGE  0
`define RTCT_R_INITIALIZATION_SECURITY   1
`define RTCT_R_CALIBRATION_PRIVILEGE   2
`define RTCT_R_CALIBRATION_SECURITY    3
// Tamper configuration fields
`define RTCT_T_IT3IE     0
`define RTCT_T_IT3BLOCK  1
// Alarm subsecond mask field position
`define RTCT_SS_MASK_LSB 24
// Counts: kernel tick divider, init sync ticks, tamper blind windows
`define RTCT_KCLK_DIV    610
`define RTCT_INIT_TICKS  2'h2
`define RTCT_TSCLR_APB   3'h4
`define RTCT_TSCLR_APRE  2'h2
`define RTCT_PREDIV_A    127
`define RTCT_PREDIV_S    255
`define RTCT_DAY_SECS    17'h1517F
`endif

// ==== rtct_calendar.v ====
// Purpose: Prescalers, subsecond downcounter and second/day calendar
// Assumes: kclk_en_i is a one-cycle kernel tick; run_i gates all counting
// Notes:   Loads from software take effect at once; a time load also resets the subsecond count
`timescale 1ns/1ps
`default_nettype none
`include "rtct_regs.vh"
module rtct_calendar #(
  parameter PREDIV_A = `RTCT_PREDIV_A,
  parameter PREDIV_S = `RTCT_PREDIV_S
) (
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        reset_i,
  // Control
  input  wire        kclk_en_i,
  input  wire        run_i,
  input  wire        load_time_i,
  input  wire        load_date_i,
  input  wire [31:0] wdata_i,
  // Calendar state
  output reg  [14:0] subsec_o,
  output reg  [16:0] secs_o,
  output reg  [15:0] days_o,
  output reg         apre_tick_o
);
  reg [6:0] apre_cnt_reg;
  wire      apre_en = kclk_en_i & run_i & (apre_cnt_reg == 7'h00);

  ////////////////////////////////////////////////////////////////////////
  // Asynchronous prescaler, the source of the subsecond clock
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      apre_cnt_reg <= PREDIV_A[6:0];
      apre_tick_o  <= 1'b0;
    end else begin
      apre_tick_o <= apre_en;
      if (kclk_en_i && run_i) begin
        apre_cnt_reg <= (apre_cnt_reg == 7'h00) ? PREDIV_A[6:0] : apre_cnt_reg - 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Subsecond downcounter, seconds of day and day count
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      subsec_o <= PREDIV_S[14:0];
      secs_o   <= 17'h00000;
      days_o   <= 16'h0000;
    end else if (load_time_i) begin
      secs_o   <= wdata_i[16:0];
      subsec_o <= PREDIV_S[14:0];
    end else if (load_date_i) begin
      days_o <= wdata_i[15:0];
    end else if (apre_en) begin
      if (subsec_o == 15'h0000) begin
        subsec_o <= PREDIV_S[14:0];
        if (secs_o >= `RTCT_DAY_SECS) begin
          secs_o <= 17'h00000;
          days_o <= days_o + 16'h0001;
        end else begin
          secs_o <= secs_o + 17'h00001;
        end
      end else begin
        subsec_o <= subsec_o - 15'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtct_core_properties.sv ====
// Purpose: Port-level assertions for rtct_core
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
`include "rtct_regs.vh"
module rtct_core_props #(
  parameter RTC_VERSION  = 32'h0000_0011,  // Arbitrary value
  parameter TAMP_VERSION = 32'h0000_0022   // Arbitrary value
) (
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        reset_i,
  // Register port
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  // Pins
  input wire logic        osc_stopped_i,
  input wire logic        secrets_erase_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////////////////
  logic ctrl0_q;
  // Init request bit as software last wrote it
  always_ff @(posedge core_clk_i) begin
    if (reset_i)
      ctrl0_q <= 1'b0;
    else if (wr_i && addr_i == `RTCT_CTRL)
      ctrl0_q <= wdata_i[0];
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data nonzero outside a read answer");
  a_ver_rtc: assert property (rd_i && addr_i == `RTCT_VER_RTC |=> rdata_o == RTC_VERSION)
    else $error("rtc version read wrong");
  a_ver_tamp: assert property (rd_i && addr_i == `RTCT_VER_TAMP |=> rdata_o == TAMP_VERSION)
    else $error("tamper version read wrong");
  a_unmapped_zero: assert property (rd_i && addr_i == 8'hFC |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_erase_pulse: assert property (secrets_erase_o |=> !secrets_erase_o)
    else $error("erase pulse longer than one cycle");
  a_erase_cause: assert property (secrets_erase_o |-> $past(osc_stopped_i, 2))
    else $error("erase without oscillator stop");
  a_ts_osc_low: assert property (osc_stopped_i [*6] ##0 (rd_i && addr_i == `RTCT_STATUS)
    |=> !rdata_o[4] && !rdata_o[6])
    else $error("timestamp flags high while oscillator stopped");
  a_init_not_at_once: assert property ((wr_i && addr_i == `RTCT_CTRL && wdata_i[0] && !ctrl0_q)
    ##2 (rd_i && addr_i == `RTCT_STATUS) |=> !rdata_o[0])
    else $error("init ready raised at once");
  // Main scenarios reached
  c_init: cover property (wr_i && addr_i == `RTCT_CTRL && wdata_i[0]);
  c_ts_read: cover property (rd_i && addr_i == `RTCT_TS_TIME);
  c_erase: cover property (secrets_erase_o);
endmodule
`default_nettype wire

// ==== tb_rtct_core.sv ====
// Purpose: Self-checking bench for rtct_core
// Assumes: Kernel tick shortened to every 4 cycles
// Notes:   Expectations are fixed in the bench, except subsecond values read back from the design
`timescale 1ns/1ps
`default_nettype none
`include "rtct_regs.vh"
module tb_rtct_core;
  localparam int          KDIV  = 4;
  localparam int          SSTK  = KDIV * 128;     // Cycles per subsecond tick
  localparam logic [31:0] VER_R = 32'h0000_0011;  // Arbitrary value
  localparam logic [31:0] VER_T = 32'h0000_0022;  // Arbitrary value
  localparam logic [31:0] ALL   = 32'hFFFF_FFFF;
  logic        core_clk_i, reset_i, wr_i, rd_i, bus_priv_i, bus_sec_i;
  logic        tamper_i, osc_stopped_i, dbg_halt_i, secrets_erase_o;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, seen, seed, tval, ssv;
  int          n_errors, n_checks;
  int          n_erase = 0;
  ////////////////////////////////////////////////////////////////////////////////
  rtct_core #(.KCLK_DIV(KDIV), .RTC_VERSION(VER_R), .TAMP_VERSION(VER_T)) u_rtct_core (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .bus_priv_i(bus_priv_i), .bus_sec_i(bus_sec_i),
    .rdata_o(rdata_o), .tamper_i(tamper_i), .osc_stopped_i(osc_stopped_i),
    .dbg_halt_i(dbg_halt_i), .secrets_erase_o(secrets_erase_o));
  // 20 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  // Counts erase pulses
  always @(posedge core_clk_i) begin
    if (secrets_erase_o === 1'b1)
      n_erase <= n_erase + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i    <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, seen);
    chk($sformatf("reg %h", a), seen & m, e & m);
  endtask
  task automatic key(input logic p, input logic s);
    bus_priv_i <= p;
    bus_sec_i  <= s;
    wr(`RTCT_KEY, {24'h0, `RTCT_KEY1});
    wr(`RTCT_KEY, {24'h0, `RTCT_KEY2});
  endtask
  // Tamper pin pulse, then time for the synchroniser
  task automatic pulse;
    @(posedge core_clk_i);
    tamper_i <= 1'b1;
    cyc(4);
    tamper_i <= 1'b0;
    cyc(4);
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #(50 * 30000);
    n_errors++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_i, wr_i, rd_i, bus_priv_i, bus_sec_i} = 5'h10;
    {tamper_i, osc_stopped_i, dbg_halt_i} = 3'h0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    n_errors = 0;
    n_checks = 0;
    seed = 32'd23873;
    cyc(10);
    reset_i <= 1'b0;
    // Version words fixed and read-only, unmapped reads zero
    rc(`RTCT_VER_RTC, ALL, VER_R);
    wr(`RTCT_VER_TAMP, ALL);
    rc(`RTCT_VER_TAMP, ALL, VER_T);
    rc(8'hFC, ALL, 32'h0);
    // Unlock; calibration then needs privilege
    key(1'b1, 1'b1);
    wr(`RTCT_RIGHTS, 32'h0000_0004);
    wr(`RTCT_TAMP_CFG, 32'h0000_0001);
    seed = xs(seed);
    wr(`RTCT_TIME, seed & 32'h0000_FFFF);
    rc(`RTCT_TIME, ALL, 32'h0);
    // Init session: ready only after kernel ticks
    wr(`RTCT_CTRL, 32'h0000_0001);
    rc(`RTCT_STATUS, 32'h1, 32'h0);
    cyc(3 * KDIV);
    rc(`RTCT_STATUS, 32'h1, 32'h1);
    seed = xs(seed);
    tval = seed & 32'h0000_FFFF;
    wr(`RTCT_TIME, tval);
    seed = xs(seed);
    wr(`RTCT_DATE, seed & 32'h0000_FFFF);
    rc(`RTCT_TIME, ALL, tval);
    rc(`RTCT_DATE, ALL, seed & 32'h0000_FFFF);
    wr(`RTCT_CTRL, 32'h0);
    rc(`RTCT_STATUS, 32'h1, 32'h0);
    // Wait for the synced flag before going on
    for (int k = 0; k < 50 && seen[`RTCT_S_RSF] !== 1'b1; k++) rd(`RTCT_STATUS, seen);
    chk("synced flag", {31'h0, seen[`RTCT_S_RSF]}, 32'h1);
    // Reference-clock enable follows the calibration unlock
    wr(`RTCT_KEY, 32'h0);
    key(1'b0, 1'b0);
    rc(`RTCT_STATUS, 32'h0000_0C00, 32'h0000_0400);
    wr(`RTCT_CTRL, 32'h0000_0020);
    rc(`RTCT_CTRL, 32'h0000_0020, 32'h0);
    key(1'b1, 1'b0);
    rc(`RTCT_STATUS, 32'h0000_0C00, 32'h0000_0C00);
    wr(`RTCT_CTRL, 32'h0000_0028);
    rc(`RTCT_CTRL, 32'h0000_0020, 32'h0000_0020);
    // Timestamp, overflow, blind window after clear
    pulse();
    rc(`RTCT_STATUS, 32'h30, 32'h10);
    rc(`RTCT_TS_TIME, ALL, tval);
    pulse();
    rc(`RTCT_STATUS, 32'h30, 32'h30);
    wr(`RTCT_CLEAR, 32'h30);
    pulse();
    rc(`RTCT_STATUS, 32'h30, 32'h0);
    // Second window: flag cleared, prescaler ticks not yet passed
    pulse();
    rc(`RTCT_STATUS, 32'h30, 32'h0);
    cyc(3 * SSTK);
    pulse();
    rc(`RTCT_STATUS, 32'h30, 32'h10);
    // Alarm A on seconds and all subsecond bits
    wr(`RTCT_ALRA, tval);
    rd(`RTCT_SUBSEC, ssv);
    wr(`RTCT_ALRA_SS, {4'h0, 4'hF, 9'h0, ssv[14:0] - 15'h2});
    wr(`RTCT_CTRL, 32'h0000_0068);
    rc(`RTCT_STATUS, 32'h4, 32'h0);
    cyc(3 * SSTK);
    rc(`RTCT_STATUS, 32'h4, 32'h4);
    // Halted core with stop-in-debug freezes subseconds
    wr(`RTCT_CTRL, 32'h0000_002C);
    dbg_halt_i <= 1'b1;
    cyc(4);
    rd(`RTCT_SUBSEC, ssv);
    cyc(2 * SSTK);
    rc(`RTCT_SUBSEC, ALL, ssv);
    dbg_halt_i <= 1'b0;
    // Oscillator stop: tamper 3 flags, erase, timestamp held low
    seed = xs(seed);
    wr(`RTCT_BKP_BASE, seed);
    rc(`RTCT_BKP_BASE, ALL, seed);
    osc_stopped_i <= 1'b1;
    cyc(8);
    rc(`RTCT_STATUS, 32'h50, 32'h0);
    rc(`RTCT_STATUS, 32'h380, 32'h380);
    rc(`RTCT_BKP_BASE, ALL, 32'h0);
    chk("erase pulses", n_erase, 32'h1);
    osc_stopped_i <= 1'b0;
    cyc(8);
    wr(`RTCT_CLEAR, 32'h80);
    rc(`RTCT_STATUS, 32'h180, 32'h0);
    // Block-only setting keeps backups but hides them while flagged
    wr(`RTCT_TAMP_CFG, 32'h0000_0003);
    wr(`RTCT_BKP_BASE, tval);
    osc_stopped_i <= 1'b1;
    cyc(8);
    rc(`RTCT_BKP_BASE, ALL, 32'h0);
    chk("erase pulses", n_erase, 32'h1);
    osc_stopped_i <= 1'b0;
    cyc(8);
    wr(`RTCT_CLEAR, 32'h80);
    rc(`RTCT_BKP_BASE, ALL, tval);
    // Timestamping resumes once the oscillator runs again
    pulse();
    rc(`RTCT_STATUS, 32'h10, 32'h10);
    report_and_stop();
  end
endmodule
bind rtct_core rtct_core_props #(.RTC_VERSION(RTC_VERSION), .TAMP_VERSION(TAMP_VERSION))
  u_rtct_core_props (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .osc_stopped_i(osc_stopped_i),
  .secrets_erase_o(secrets_erase_o));
`default_nettype wire
